// ==== sync_pkg.sv ====
// constants, carrier types and helper functions of the synchronizer mode block
// assumes a single 100 MHz clock and software access over AXI4-Lite
package sync_pkg;
   localparam int CLK_PERIOD_NS = 10;
   localparam int MS_NS = 1000000;
   localparam int CYCLES_PER_MS = MS_NS / CLK_PERIOD_NS;

   localparam logic [7:0] ADDR_CONFIG = 8'h00;
   localparam logic [7:0] ADDR_MODE_CMD = 8'h04;
   localparam logic [7:0] ADDR_CLOSE_TIME = 8'h08;
   localparam logic [7:0] ADDR_GAINS = 8'h0c;
   localparam logic [7:0] ADDR_STATUS = 8'h10;

   localparam int CFG_SYNC_LSB = 0;
   localparam int CFG_VMATCH_BIT = 2;
   localparam int CFG_DBEN_BIT = 3;
   localparam int CFG_RANGE_LSB = 4;
   localparam int CFG_BKR_BIT = 6;
   localparam int GAIN_KI_LSB = 16;

   localparam logic [6:0] CONFIG_RST = 7'h05;
   localparam logic [15:0] CLOSE_MS_RST = 16'h00c8;
   localparam logic [15:0] KP_RST = 16'h0100;
   localparam logic [15:0] KI_RST = 16'h0010;

   localparam logic [9:0] DEAD_LVL_LOW_V = 10'd27;
   localparam logic [9:0] DEAD_LVL_MID_V = 10'd40;
   localparam logic [9:0] DEAD_LVL_HIGH_V = 10'd80;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {MODE_OFF, MODE_CHECK, MODE_PERMISSIVE, MODE_RUN} mode_type;
   typedef enum logic [1:0] {SYNC_OFF, SYNC_PHASE, SYNC_SLIP} sync_kind_type;

   typedef struct packed {
      logic speed_raise;
      logic speed_lower;
      logic volt_raise;
      logic volt_lower;
   } manual_type;

   typedef struct packed {
      logic valid;
      mode_type mode;
   } mode_cmd_type;

   typedef struct packed {
      logic phase_ok;
      logic freq_ok;
      logic volt_ok;
      logic volt_low;
      logic [9:0] bus_volts;
      logic [1:0] aux_closed;
      logic signed [15:0] speed_err;
   } meas_type;

   typedef struct packed {
      logic bkr_sel;
      logic [1:0] range;
      logic dead_bus_en;
      logic volt_match_en;
      logic [1:0] sync_kind;
   } cfg_type;

   function automatic logic [9:0] dead_level(input logic [1:0] range);
      case (range)
         2'd0: dead_level = DEAD_LVL_LOW_V;
         2'd1: dead_level = DEAD_LVL_MID_V;
         default: dead_level = DEAD_LVL_HIGH_V;
      endcase
   endfunction : dead_level

   function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] strb);
      for (int i = 0; i < 4; i++) begin
         wmerge[i*8 +: 8] = strb[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
      end
   endfunction : wmerge
endpackage : sync_pkg

// ==== sync_pi_loop.sv ====
// proportional-integral speed correction for the synchronizer
// assumes err is a signed phase/slip error sampled every clock
`timescale 1ns/10ps
module sync_pi_loop
   import sync_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic enable,
   input wire logic signed [15:0] err,
   input wire logic [15:0] kp,
   input wire logic [15:0] ki,
   output logic signed [15:0] bias
);
   typedef struct packed {
      logic signed [39:0] integ;
      logic signed [15:0] bias;
   } pi_state_type;

   pi_state_type q, d;
   logic signed [39:0] sum;

   always_comb begin
      d = q;
      sum = 40'sd0;
      if (!enable) begin
         // integrator cleared so a new attempt starts without windup
         d = '0;
      end else begin
         // widen before multiplying so the product is not cut to 17 bits
         d.integ = q.integ + 40'(err) * 40'($signed({1'b0, ki}));
         sum = 40'(err) * 40'($signed({1'b0, kp})) + q.integ;
         sum = sum >>> 8;
         if (sum > 40'sd32767) begin
            d.bias = 16'sh7fff;
         end else if (sum < -40'sd32768) begin
            d.bias = -16'sh8000;
         end else begin
            d.bias = sum[15:0];
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign bias = q.bias;

   a_pi_idle_zero: assert property (@(posedge aclk) disable iff (!aresetn)
      !enable |=> bias == 16'sh0000) else $error("bias not zero while disabled");
endmodule : sync_pi_loop

// ==== sync_close_timer.sv ====
// counts the length of a breaker close command
// assumes run stays high for the whole command and drops after it
`timescale 1ns/10ps
module sync_close_timer
   import sync_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic run,
   input wire logic [15:0] limit_ms,
   output logic expired
);
   typedef struct packed {
      logic [39:0] count;
   } tmr_state_type;

   tmr_state_type q, d;
   logic [39:0] limit;

   always_comb begin
      limit = 40'(limit_ms) * 40'(CYCLES_PER_MS);
      d = q;
      if (!run) begin
         d.count = '0;
      end else if (q.count < limit) begin
         d.count = q.count + 40'd1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // a zero time expires at once rather than never
   assign expired = run && (q.count >= limit);

   a_timer_bounded: assert property (@(posedge aclk) disable iff (!aresetn)
      run && !expired |=> q.count == $past(q.count) + 40'd1 || !run)
      else $error("close timer did not advance");
endmodule : sync_close_timer

// ==== sync_ctrl.sv ====
// synchronizer mode selection, output gating, close sequencing and dead bus
// assumes measurement flags arrive synchronous to aclk from the analog front end
//
// Our own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module sync_ctrl
   import sync_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic mode_auto,
   input wire mode_cmd_type panel_cmd,
   input wire mode_cmd_type [1:0] link_cmd,
   input wire manual_type manual,
   input wire meas_type meas,
   input wire logic peer_token,
   output mode_type active_mode,
   output logic speed_bias_en,
   output logic signed [15:0] speed_bias,
   output logic volt_raise,
   output logic volt_lower,
   output logic [1:0] close_cmd,
   output manual_type net_bias,
   output logic dead_bus_ack
);
   typedef struct packed {
      cfg_type cfg;
      mode_type cmd;
      logic [15:0] close_ms;
      logic [15:0] kp;
      logic [15:0] ki;
      logic done;
      logic dead;
      logic token;
      logic ack;
      logic closing;
      mode_type mode;
      logic sb_en;
      logic vr;
      logic vl;
      logic [1:0] close;
      manual_type net;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
   } ctrl_state_type;

   ctrl_state_type q, d;
   logic aw_go;
   logic ar_go;
   logic forced_off;
   logic sync_ok;
   logic db_permit;
   logic want_close;
   logic end_evt;
   logic aux_sel;
   logic expired;
   logic [31:0] wd;

   ////////////////////////////////////////////////////////////////////////////////
   // bus handshakes: address and data are taken together, one write in flight

   assign aw_go = s_axi_awvalid && s_axi_wvalid && !q.bvalid;
   assign ar_go = s_axi_arvalid && !q.rvalid;
   assign s_axi_awready = aw_go;
   assign s_axi_wready = aw_go;
   assign s_axi_arready = !q.rvalid;

   ////////////////////////////////////////////////////////////////////////////////
   // next-state logic

   always_comb begin
      d = q;
      wd = '0;
      forced_off = 1'b0;
      sync_ok = 1'b0;
      db_permit = 1'b0;
      want_close = 1'b0;
      end_evt = 1'b0;
      aux_sel = 1'b0;

      // mode command sources; a later assignment wins a same-cycle tie
      if (panel_cmd.valid) begin
         d.cmd = panel_cmd.mode;
      end
      for (int i = 0; i < 2; i++) begin
         if (link_cmd[i].valid) begin
            d.cmd = link_cmd[i].mode;
         end
      end

      // register writes
      if (q.bvalid && s_axi_bready) begin
         d.bvalid = 1'b0;
      end
      if (aw_go) begin
         d.bvalid = 1'b1;
         d.bresp = RESP_OKAY;
         case (s_axi_awaddr)
            ADDR_CONFIG: begin
               wd = wmerge({25'h0, q.cfg}, s_axi_wdata, s_axi_wstrb);
               d.cfg = wd[6:0];
            end
            ADDR_MODE_CMD: begin
               if (s_axi_wstrb[0]) begin
                  d.cmd = mode_type'(s_axi_wdata[1:0]);
               end
            end
            ADDR_CLOSE_TIME: begin
               wd = wmerge({16'h0, q.close_ms}, s_axi_wdata, s_axi_wstrb);
               d.close_ms = wd[15:0];
            end
            ADDR_GAINS: begin
               wd = wmerge({q.ki, q.kp}, s_axi_wdata, s_axi_wstrb);
               d.kp = wd[15:0];
               d.ki = wd[31:GAIN_KI_LSB];
            end
            default: d.bresp = RESP_SLVERR;
         endcase
      end

      // register reads
      if (q.rvalid && s_axi_rready) begin
         d.rvalid = 1'b0;
      end
      if (ar_go) begin
         d.rvalid = 1'b1;
         d.rresp = RESP_OKAY;
         case (s_axi_araddr)
            ADDR_CONFIG: d.rdata = {25'h0, q.cfg};
            ADDR_MODE_CMD: d.rdata = {30'h0, q.cmd};
            ADDR_CLOSE_TIME: d.rdata = {16'h0, q.close_ms};
            ADDR_GAINS: d.rdata = {q.ki, q.kp};
            ADDR_STATUS: begin
               d.rdata = {22'h0, q.vl, q.vr, q.close, q.sb_en, q.done, q.token,
                          q.dead, q.mode};
            end
            default: begin
               d.rdata = '0;
               d.rresp = RESP_SLVERR;
            end
         endcase
      end

      // dead bus detection and token handling
      d.dead = meas.bus_volts < dead_level(q.cfg.range);
      d.ack = d.dead && !q.dead;
      if (!d.dead) begin
         d.token = 1'b0;
      end else if (peer_token) begin
         d.token = 1'b1;
      end

      // closing ends on the selected breaker's aux contact or, in Run only, the close timer
      aux_sel = meas.aux_closed[q.cfg.bkr_sel];
      end_evt = (q.close != 2'b00) && (aux_sel || (q.mode == MODE_RUN && expired));
      // done latches until Auto is cycled off
      d.done = (q.done || end_evt) && mode_auto;

      // mode: forced off overrides the latest command
      forced_off = !mode_auto || (q.cfg.sync_kind == SYNC_OFF) || d.done;
      d.mode = forced_off ? MODE_OFF : d.cmd;

      // closure permission
      sync_ok = meas.phase_ok && meas.freq_ok && (meas.volt_ok || !q.cfg.volt_match_en);
      db_permit = !aux_sel && q.cfg.dead_bus_en && q.dead && q.token;
      want_close = (sync_ok || db_permit) && !aux_sel;

      case (d.mode)
         MODE_RUN: begin
            // once started, the command is held until it ends
            d.closing = q.closing || want_close;
            d.sb_en = 1'b1;
         end
         MODE_PERMISSIVE: begin
            d.closing = want_close;
            d.sb_en = 1'b0;
         end
         MODE_CHECK: begin
            d.closing = 1'b0;
            d.sb_en = 1'b1;
         end
         default: begin
            d.closing = 1'b0;
            d.sb_en = 1'b0;
         end
      endcase

      // one close output per breaker, only the selected one driven
      d.close = 2'b00;
      d.close[q.cfg.bkr_sel] = d.closing;

      // voltage matching is frozen while a Run close command is out; Permissive holds both outputs low
      // next config is used so the outputs drop on the edge that disables matching
      if (!d.cfg.volt_match_en || !(d.mode == MODE_RUN || d.mode == MODE_CHECK)) begin
         d.vr = 1'b0;
         d.vl = 1'b0;
      end else if (!(d.mode == MODE_RUN && q.closing)) begin
         d.vr = !meas.volt_ok && meas.volt_low;
         d.vl = !meas.volt_ok && !meas.volt_low;
      end

      // panel switches reach the network only in Off and Permissive
      if (d.mode == MODE_OFF || d.mode == MODE_PERMISSIVE) begin
         d.net = manual;
      end else begin
         d.net = '0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // state register

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= '0;
         q.cfg <= CONFIG_RST;
         q.close_ms <= CLOSE_MS_RST;
         q.kp <= KP_RST;
         q.ki <= KI_RST;
      end else begin
         q <= d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // helpers

   sync_pi_loop u_pi (
      .aclk(aclk),
      .aresetn(aresetn),
      .enable(q.sb_en),
      .err(meas.speed_err),
      .kp(q.kp),
      .ki(q.ki),
      .bias(speed_bias)
   );

   sync_close_timer u_timer (
      .aclk(aclk),
      .aresetn(aresetn),
      .run(q.closing),
      .limit_ms(q.close_ms),
      .expired(expired)
   );

   assign s_axi_bvalid = q.bvalid;
   assign s_axi_bresp = q.bresp;
   assign s_axi_rvalid = q.rvalid;
   assign s_axi_rresp = q.rresp;
   assign s_axi_rdata = q.rdata;
   assign active_mode = q.mode;
   assign speed_bias_en = q.sb_en;
   assign volt_raise = q.vr;
   assign volt_lower = q.vl;
   assign close_cmd = q.close;
   assign net_bias = q.net;
   assign dead_bus_ack = q.ack;

   ////////////////////////////////////////////////////////////////////////////////
   // checks

   a_off_all_disabled: assert property (@(posedge aclk) disable iff (!aresetn)
      q.mode == MODE_OFF |-> !q.sb_en && q.close == 2'b00 && !q.vr && !q.vl)
      else $error("output active in off mode");

   a_off_no_auto: assert property (@(posedge aclk) disable iff (!aresetn)
      !mode_auto |=> q.mode == MODE_OFF) else $error("mode not off without auto");

   a_run_needs_auto: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(q.mode == MODE_RUN) |-> $past(mode_auto)) else $error("run without auto");

   a_manual_ignored: assert property (@(posedge aclk) disable iff (!aresetn)
      q.mode == MODE_RUN || q.mode == MODE_CHECK |-> q.net == '0)
      else $error("panel switches forwarded in run or check");

   a_manual_forward: assert property (@(posedge aclk) disable iff (!aresetn)
      mode_auto == 1'b0 ##1 mode_auto == 1'b0 |-> q.net == $past(manual))
      else $error("panel switches not forwarded in off mode");

   a_check_no_close: assert property (@(posedge aclk) disable iff (!aresetn)
      q.mode == MODE_CHECK |-> q.close == 2'b00 && q.sb_en)
      else $error("close issued in check mode");

   a_perm_no_bias: assert property (@(posedge aclk) disable iff (!aresetn)
      q.mode == MODE_PERMISSIVE |-> !q.sb_en && !q.vr && !q.vl)
      else $error("bias active in permissive mode");

   a_vmatch_off: assert property (@(posedge aclk) disable iff (!aresetn)
      !q.cfg.volt_match_en |-> !q.vr && !q.vl) else $error("voltage command without matching");

   a_aux_ends_close: assert property (@(posedge aclk) disable iff (!aresetn)
      q.close != 2'b00 && meas.aux_closed[q.cfg.bkr_sel] |=> q.close == 2'b00
      && q.mode == MODE_OFF) else $error("close not ended by aux contact");

   a_run_holds_bias: assert property (@(posedge aclk) disable iff (!aresetn)
      q.mode == MODE_RUN && q.close != 2'b00 |-> q.sb_en) else $error("bias dropped in close");

   a_dead_detect: assert property (@(posedge aclk) disable iff (!aresetn)
      meas.bus_volts < dead_level(q.cfg.range) && $stable(q.cfg.range) |=> q.dead)
      else $error("dead bus not flagged");

   a_ack_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
      q.ack |-> q.dead && !$past(q.dead) ##1 !q.ack) else $error("ack not a single pulse");

   a_deadbus_perm: assert property (@(posedge aclk) disable iff (!aresetn)
      q.close != 2'b00 && $rose(q.closing) && !$past(meas.phase_ok) |->
      $past(q.cfg.dead_bus_en) && $past(q.token)) else $error("dead bus close without permit");
endmodule : sync_ctrl

// ==== sync_peer_net.sv ====
// model of the peer load-sharing units on the control network
// assumes dead_bus_ack is a one-cycle pulse synchronous to aclk; delay sets how slow peers are
`timescale 1ns/10ps
module sync_peer_net
   import sync_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic dead_bus_ack,
   input wire logic [7:0] delay,
   output logic peer_token
);
   logic [7:0] count_ff;
   logic pending_ff;

   // every peer has to see the acknowledgement before the token comes back
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count_ff <= 8'h00;
         pending_ff <= 1'b0;
         peer_token <= 1'b0;
      end else begin
         peer_token <= 1'b0;
         if (dead_bus_ack) begin
            pending_ff <= 1'b1;
            count_ff <= delay;
         end else if (pending_ff && count_ff != 8'h00) begin
            count_ff <= count_ff - 8'h01;
         end else if (pending_ff) begin
            pending_ff <= 1'b0;
            peer_token <= 1'b1;
         end
      end
   end
endmodule : sync_peer_net

// ==== tb_sync_mode_breaker_interlock.sv ====
// self-checking bench of the synchronizer mode, gating and interlock block
// assumes sync_pkg, the design files and sync_peer_net are compiled before it
`timescale 1ns/10ps
module tb_sync_mode_breaker_interlock
   import sync_pkg::*;
;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [31:0] s_axi_wdata = 32'h0000_0000;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, close_cmd;
   logic [31:0] s_axi_rdata;
   logic mode_auto = 1'b0;
   mode_cmd_type panel_cmd = '0;
   mode_cmd_type [1:0] link_cmd = '0;
   manual_type manual = '0;
   meas_type meas = {4'h0, 10'h0f0, 2'b00, 16'h0000};
   logic peer_token, speed_bias_en, volt_raise, volt_lower, dead_bus_ack;
   logic [7:0] delay = 8'h0c;
   mode_type active_mode;
   logic signed [15:0] speed_bias;
   manual_type net_bias;
   int errors = 0;
   int num_checks = 0;
   logic [1:0] resp;
   logic [31:0] rd;
   logic close0;

   assign close0 = close_cmd[0];

   always #5 aclk = ~aclk;

   sync_ctrl dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .mode_auto(mode_auto), .panel_cmd(panel_cmd),
      .link_cmd(link_cmd), .manual(manual), .meas(meas), .peer_token(peer_token),
      .active_mode(active_mode), .speed_bias_en(speed_bias_en), .speed_bias(speed_bias),
      .volt_raise(volt_raise), .volt_lower(volt_lower), .close_cmd(close_cmd),
      .net_bias(net_bias), .dead_bus_ack(dead_bus_ack));

   sync_peer_net peers (.aclk(aclk), .aresetn(aresetn), .dead_bus_ack(dead_bus_ack),
      .delay(delay), .peer_token(peer_token));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic end_of_test;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : end_of_test

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   // every wait is bounded so a dead handshake ends the run instead of hanging it
   task automatic wait_hi(ref logic s, input string name);
      int n;
      n = 0;
      @(negedge aclk);
      while (s !== 1'b1) begin
         n++;
         if (n > 50) begin
            errors++;
            $display("ERROR %s expected 1 seen timeout", name);
            end_of_test();
         end
         @(negedge aclk);
      end
   endtask : wait_hi

   task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      wait_hi(s_axi_awready, "awready");
      @(posedge aclk);
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      wait_hi(s_axi_bvalid, "bvalid");
      r = s_axi_bresp;
      @(posedge aclk);
      s_axi_bready <= 1'b0;
   endtask : axw

   task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      wait_hi(s_axi_arready, "arready");
      @(posedge aclk);
      s_axi_arvalid <= 1'b0;
      wait_hi(s_axi_rvalid, "rvalid");
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      s_axi_rready <= 1'b0;
   endtask : axr

   task automatic cmd(input int src, input mode_type m);
      @(posedge aclk);
      if (src == 0) panel_cmd <= '{1'b1, m};
      else link_cmd[src-1] <= '{1'b1, m};
      @(posedge aclk);
      panel_cmd <= '0;
      link_cmd <= '0;
      repeat (2) @(negedge aclk);
   endtask : cmd

   task automatic cond(input logic v);
      @(posedge aclk);
      meas.phase_ok <= v;
      meas.freq_ok <= v;
      meas.volt_ok <= v;
   endtask : cond

   task automatic auto_cycle;
      @(posedge aclk);
      mode_auto <= 1'b0;
      meas.aux_closed <= 2'b00;
      repeat (2) @(posedge aclk);
      mode_auto <= 1'b1;
   endtask : auto_cycle

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_regs;
      axr(ADDR_CONFIG, rd, resp);
      chk("config", {25'h0, CONFIG_RST}, rd);
      axr(ADDR_CLOSE_TIME, rd, resp);
      chk("close_time", {16'h0, CLOSE_MS_RST}, rd);
      axr(ADDR_GAINS, rd, resp);
      chk("gains", {KI_RST, KP_RST}, rd);
      axr(8'h14, rd, resp);
      chk("rresp", RESP_SLVERR, resp);
      chk("rdata", 32'h0000_0000, rd);
      axw(8'h14, 32'hffff_ffff, resp);
      chk("bresp", RESP_SLVERR, resp);
      axw(ADDR_GAINS, 32'h0000_0100, resp);
      axr(ADDR_GAINS, rd, resp);
      chk("gains", 32'h0000_0100, rd);
   endtask : t_regs

   task automatic t_off;
      @(posedge aclk);
      manual <= 4'b1010;
      cond(1'b1);
      cmd(0, MODE_RUN);
      chk("mode", MODE_OFF, active_mode);
      chk("net_bias", 4'b1010, net_bias);
      chk("bias_en", 1'b0, speed_bias_en);
      chk("close", 2'b00, close_cmd);
      chk("volt", 2'b00, {volt_raise, volt_lower});
   endtask : t_off

   task automatic t_check;
      for (int s = 0; s < 2; s++) begin
         axw(ADDR_CONFIG, 32'h0000_0005 | (s << CFG_BKR_BIT), resp);
         cmd(0, MODE_CHECK);
         repeat (3) @(negedge aclk);
         chk("mode", MODE_CHECK, active_mode);
         chk("close", 2'b00, close_cmd);
         chk("bias_en", 1'b1, speed_bias_en);
         chk("net_bias", 4'b0000, net_bias);
      end
      @(posedge aclk);
      meas.volt_ok <= 1'b0;
      meas.volt_low <= 1'b1;
      repeat (3) @(negedge aclk);
      chk("volt_raise", 1'b1, volt_raise);
   endtask : t_check

   task automatic t_perm;
      cond(1'b1);
      cmd(1, MODE_PERMISSIVE);
      chk("close", 2'b10, close_cmd);
      chk("bias_en", 1'b0, speed_bias_en);
      chk("volt", 2'b00, {volt_raise, volt_lower});
      chk("net_bias", 4'b1010, net_bias);
      @(posedge aclk);
      meas.freq_ok <= 1'b0;
      repeat (2) @(negedge aclk);
      chk("close", 2'b00, close_cmd);
   endtask : t_perm

   task automatic t_run_aux;
      logic [1:0] v;
      axw(ADDR_CONFIG, 32'h0000_0005, resp);
      cond(1'b0);
      @(posedge aclk);
      meas.speed_err <= 16'sd100;
      meas.volt_low <= 1'b1;
      cmd(2, MODE_RUN);
      repeat (3) @(negedge aclk);
      chk("mode", MODE_RUN, active_mode);
      chk("net_bias", 4'b0000, net_bias);
      chk("bias", 16'sd100, speed_bias);
      cond(1'b1);
      wait_hi(close0, "close");
      v = {volt_raise, volt_lower};
      // the voltage command must not follow the inputs while the close is out
      @(posedge aclk);
      meas.volt_low <= 1'b0;
      meas.volt_ok <= 1'b0;
      repeat (3) @(negedge aclk);
      chk("close", 2'b01, close_cmd);
      chk("bias_en", 1'b1, speed_bias_en);
      chk("volt", v, {volt_raise, volt_lower});
      @(posedge aclk);
      meas.aux_closed <= 2'b01;
      repeat (3) @(negedge aclk);
      chk("mode", MODE_OFF, active_mode);
      chk("close", 2'b00, close_cmd);
      cmd(0, MODE_RUN);
      chk("mode", MODE_OFF, active_mode);
      auto_cycle();
   endtask : t_run_aux

   task automatic t_timeout;
      int n;
      logic seen;
      seen = 1'b0;
      axw(ADDR_CLOSE_TIME, 32'h0000_0000, resp);
      cmd(0, MODE_RUN);
      cond(1'b1);
      for (n = 0; n < 20 && active_mode !== MODE_OFF; n++) begin
         seen = seen | close_cmd[0];
         @(negedge aclk);
      end
      chk("close_seen", 1'b1, seen);
      chk("mode", MODE_OFF, active_mode);
      // park the stored command so Auto coming back does not start another close
      cmd(0, MODE_OFF);
      auto_cycle();
   endtask : t_timeout

   task automatic t_misc;
      axw(ADDR_CONFIG, 32'h0000_0001, resp);
      @(posedge aclk);
      meas.volt_low <= 1'b1;
      meas.volt_ok <= 1'b0;
      meas.phase_ok <= 1'b0;
      @(posedge aclk);
      panel_cmd <= '{1'b1, MODE_RUN};
      link_cmd[1] <= '{1'b1, MODE_CHECK};
      @(posedge aclk);
      panel_cmd <= '0;
      link_cmd <= '0;
      repeat (3) @(negedge aclk);
      chk("mode", MODE_CHECK, active_mode);
      chk("volt", 2'b00, {volt_raise, volt_lower});
      axw(ADDR_MODE_CMD, 32'h0000_0002, resp);
      @(negedge aclk);
      chk("mode", MODE_PERMISSIVE, active_mode);
      axw(ADDR_CONFIG, 32'h0000_0004, resp);
      repeat (2) @(negedge aclk);
      chk("mode", MODE_OFF, active_mode);
   endtask : t_misc

   task automatic t_dead;
      int acks;
      acks = 0;
      axw(ADDR_CONFIG, 32'h0000_002d, resp);
      @(posedge aclk);
      meas.bus_volts <= 10'd80;
      repeat (4) @(negedge aclk);
      chk("ack", 1'b0, dead_bus_ack);
      @(posedge aclk);
      meas.bus_volts <= 10'd79;
      repeat (6) begin
         @(negedge aclk);
         acks += int'(dead_bus_ack === 1'b1);
      end
      chk("ack_count", 32'd1, acks);
      axr(ADDR_STATUS, rd, resp);
      chk("dead_token", 2'b01, rd[3:2]);
      chk("close", 2'b00, close_cmd);
      repeat (20) @(negedge aclk);
      axr(ADDR_STATUS, rd, resp);
      chk("dead_token", 2'b11, rd[3:2]);
      chk("close", 2'b01, close_cmd);
      @(posedge aclk);
      meas.bus_volts <= 10'd240;
      axr(ADDR_STATUS, rd, resp);
      chk("dead", 1'b0, rd[2]);
   endtask : t_dead

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs();
      t_off();
      @(posedge aclk);
      mode_auto <= 1'b1;
      t_check();
      t_perm();
      t_run_aux();
      t_timeout();
      t_misc();
      t_dead();
      end_of_test();
   end

   // a stuck sequence is cut short here and reported as a mismatch
   initial begin
      repeat (20000) @(posedge aclk);
      errors++;
      $display("ERROR watchdog expected finish seen timeout");
      end_of_test();
   end
endmodule : tb_sync_mode_breaker_interlock
